// file: logic/flc_pkg.sv
// Package for the flash LED control block: constants and carriers.
// Assumes one 25 MHz system clock and an oversampling link clock.
package flc_pkg;
  // Target address and register field positions.
  localparam logic [6:0] I2C_ADDR = 7'h28;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RETAIN_BIT = 5;
  localparam int GAIN_HI = 4;
  localparam int GAIN_LO = 3;
  localparam int TMO_HI = 1;
  localparam int TMO_LO = 0;
  localparam int CEIL_HI = 7;
  localparam int CEIL_LO = 5;
  localparam int EN_HI = 7;
  localparam int EN_LO = 5;
  localparam int FC_HI = 4;
  localparam int FC_LO = 2;
  localparam int TC_HI = 4;
  localparam int TC_LO = 1;
  // Mode and gain codes of the mode control register.
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h1;
  localparam logic [1:0] MODE_ATORCH = 2'h2;
  localparam logic [1:0] MODE_FLASH = 2'h3;
  localparam logic [1:0] GAIN_AUTO = 2'h0;
  localparam logic [1:0] GAIN_1X = 2'h1;
  localparam logic [1:0] GAIN_15X = 2'h2;
  localparam logic [1:0] GAIN_2X = 2'h3;
  // Byte positions within one transfer.
  localparam logic [1:0] IX_MODE = 2'h0;
  localparam logic [1:0] IX_FLASH = 2'h1;
  localparam logic [1:0] IX_TORCH = 2'h2;
  localparam logic [1:0] IX_CEIL = 2'h3;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Timing, in its own units, and the system clock rate.
  localparam int SYS_KHZ = 25000;
  localparam int FLASH_MS_0 = 110;
  localparam int FLASH_MS_1 = 220;
  localparam int FLASH_MS_2 = 530;
  localparam int FLASH_MS_3 = 1100;
  localparam int TMR_W = 25;
  // Output ceiling in millivolts.
  localparam int MV_W = 13;
  localparam logic [12:0] CEIL_BASE_MV = 13'h11c6;
  localparam logic [12:0] CEIL_STEP_MV = 13'h0096;
  localparam logic [12:0] CEIL_TORCH_MV = 13'h1194;
  localparam logic [12:0] HYST_MV = 13'h0032;

  typedef enum logic [1:0] {G_1X, G_15X, G_2X} flc_gain_t;
  typedef enum logic [1:0] {PS_OFF, PS_RUN, PS_WAIT} flc_pst_t;
  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
  } flc_ist_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [2:0] ceil;
    logic [7:0] flash;
    logic [7:0] torch;
  } flc_cfg_t;

  typedef struct packed {
    logic above_ceil;
    logic below_rearm;
    logic below_in_1v;
    logic above_in;
    logic headroom_low;
    logic undervoltage_lockout_fault;
    logic overtemp;
  } flc_sense_t;

  typedef struct packed {
    logic [2:0] en;
    logic flash_sel;
    logic [3:0] code;
  } flc_drive_t;

  typedef struct packed {
    logic on;
    flc_gain_t gain;
    logic standby;
    logic [12:0] ceil_mv;
    logic [12:0] rearm_mv;
  } flc_pump_t;
endpackage : flc_pkg

// file: logic/flc_top.sv
// Flash LED driver control: I2C target, register set, pump control.
// Assumes analog comparators deliver the sense levels and that the
// link clock oversamples the I2C pins at least four times per bit.
//
// Overview of operation
// - Retain bit keeps or clears registers
// - Timeout bits pick flash duration
// - Ceiling from code in flash, else fixed
// - Pump waits for fifty millivolt drop
// - Charged flag mirrors output above ceiling
// - Fault flags show undervoltage, overtemperature
// - Flash enables drive channels one to three
// - Flash current code, three bits
// - Torch current code, four bits
// - Torch enables drive channels one to three
// - Full write stores mode, flash, torch, ceiling
// - Answer only target address 28 hex
// - Read returns status, flash, torch
// - Power-on reset clears everything
// - Operate only while enable pin high
// - Pump off while above ceiling
// - Far below input: unity gain only
// - Just below input: no double gain
// - Above input: no unity gain
// - No enabled channels above ceiling: standby
// - Efficient torch restarts on low headroom
// - Mode and gain bit decoding
// - Enable pin low clears registers
`timescale 1ns/1ps
module flc_top #(
  parameter int FLASH_CYC_0 = flc_pkg::FLASH_MS_0 * flc_pkg::SYS_KHZ,
  parameter int FLASH_CYC_1 = flc_pkg::FLASH_MS_1 * flc_pkg::SYS_KHZ,
  parameter int FLASH_CYC_2 = flc_pkg::FLASH_MS_2 * flc_pkg::SYS_KHZ,
  parameter int FLASH_CYC_3 = flc_pkg::FLASH_MS_3 * flc_pkg::SYS_KHZ
) (
  input wire logic sys_clk, // System clock.
  input wire logic nrst, // Power-on reset, active low.
  input wire logic link_clk, // Clock that samples the I2C pins.
  input wire logic shutdown_n, // Enable pin, low shuts down.
  input wire logic scl_pin, // I2C clock pin.
  input wire logic sda_pin, // I2C data pin level.
  output logic sda_drv, // I2C data drive value.
  output logic sda_oe_n, // Low while pulling data low.
  input wire flc_pkg::flc_sense_t sense, // Comparator levels.
  output flc_pkg::flc_drive_t drive, // Channel drive.
  output flc_pkg::flc_pump_t pump // Pump control.
);
  import flc_pkg::*;

  // Release of power-on reset, one copy per clock domain.
  logic [1:0] srst_q;
  logic [1:0] lrst_q;
  logic rst_n;
  logic lrst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) srst_q <= 2'h0;
    else srst_q <= {srst_q[0], 1'b1};
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) lrst_q <= 2'h0;
    else lrst_q <= {lrst_q[0], 1'b1};
  end
  assign rst_n = srst_q[1];
  assign lrst_n = lrst_q[1];

  // ---- Link domain ----
  // Pin synchronisers; the third stage only serves edge detection.
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [1:0] lsh_q;
  logic [1:0] ack_q;
  logic ack_tg_q;
  logic [2:0] flg_m_q;
  logic [2:0] flg_s_q;
  logic [2:0] sflg;
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
      lsh_q <= 2'h0;
      ack_q <= 2'h0;
      flg_m_q <= 3'h0;
      flg_s_q <= 3'h0;
    end else begin
      scl_q <= {scl_q[1:0], scl_pin};
      sda_q <= {sda_q[1:0], sda_pin};
      lsh_q <= {lsh_q[0], shutdown_n};
      ack_q <= {ack_q[0], ack_tg_q};
      flg_m_q <= sflg;
      flg_s_q <= flg_m_q;
    end
  end

  logic rise;
  logic fall;
  logic start;
  logic stop;
  assign rise = scl_q[1] && !scl_q[2];
  assign fall = !scl_q[1] && scl_q[2];
  assign start = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
  assign stop = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

  // Readback byte for a position in a read transfer.
  function automatic logic [7:0] rd_byte(input logic [1:0] i,
      input flc_cfg_t r, input logic [2:0] f);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      IX_MODE: b = {r.ceil, f, 2'h0};
      IX_FLASH: b = r.flash;
      IX_TORCH: b = r.torch;
      IX_CEIL: b = 8'h00;
    endcase
    return b;
  endfunction : rd_byte

  // Byte position advances and sticks at the last one.
  function automatic logic [1:0] inc_ix(input logic [1:0] i);
    return (i == IX_CEIL) ? i : i + 2'h1;
  endfunction : inc_ix

  flc_ist_t ist_q, ist_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [1:0] ix_q, ix_d;
  logic rw_q, rw_d;
  logic oen_q, oen_d;
  flc_cfg_t regs_q, regs_d;
  logic [7:0] rb;

  // I2C target: bits are taken on SCL rise, driven after SCL fall.
  always_comb begin
    ist_d = ist_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ix_d = ix_q;
    rw_d = rw_q;
    oen_d = oen_q;
    regs_d = regs_q;
    rb = rd_byte(ix_q, regs_q, flg_s_q);
    if (!lsh_q[1]) begin
      regs_d = '0;
      ist_d = I_IDLE;
      oen_d = 1'b1;
    end else if (start) begin
      ist_d = I_ADDR;
      cnt_d = 4'h0;
      oen_d = 1'b1;
      if (!regs_q.mode[RETAIN_BIT]) regs_d = '0;
    end else if (stop) begin
      ist_d = I_IDLE;
      oen_d = 1'b1;
    end else begin
      unique case (ist_q)
        I_IDLE: begin
        end
        I_ADDR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == BYTE_BITS) begin
            if (sh_q[7:1] == I2C_ADDR) begin
              oen_d = 1'b0;
              rw_d = sh_q[0];
              ix_d = IX_MODE;
              ist_d = I_AACK;
            end else begin
              ist_d = I_IDLE;
            end
          end
        end
        I_AACK: begin
          if (fall && rw_q) begin
            sh_d = rb;
            oen_d = rb[7];
            cnt_d = 4'h1;
            ix_d = inc_ix(ix_q);
            ist_d = I_RD;
          end else if (fall) begin
            oen_d = 1'b1;
            cnt_d = 4'h0;
            ist_d = I_WR;
          end
        end
        I_WR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_q[1]};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == BYTE_BITS) begin
            unique case (ix_q)
              IX_MODE: regs_d.mode = sh_q;
              IX_FLASH: regs_d.flash = sh_q;
              IX_TORCH: regs_d.torch = sh_q;
              IX_CEIL: regs_d.ceil = sh_q[CEIL_HI:CEIL_LO];
            endcase
            ix_d = inc_ix(ix_q);
            oen_d = 1'b0;
            ist_d = I_WACK;
          end
        end
        I_WACK: begin
          if (fall) begin
            oen_d = 1'b1;
            cnt_d = 4'h0;
            ist_d = I_WR;
          end
        end
        I_RD: begin
          if (fall && cnt_q == BYTE_BITS) begin
            oen_d = 1'b1;
            ist_d = I_RACK;
          end else if (fall) begin
            oen_d = sh_q[6];
            sh_d = {sh_q[6:0], 1'b1};
            cnt_d = cnt_q + 4'h1;
          end
        end
        I_RACK: begin
          // A high level at the ninth bit ends the read.
          if (rise && sda_q[1]) begin
            ist_d = I_IDLE;
          end else if (fall) begin
            sh_d = rb;
            oen_d = rb[7];
            cnt_d = 4'h1;
            ix_d = inc_ix(ix_q);
            ist_d = I_RD;
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ist_q <= I_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      ix_q <= IX_MODE;
      rw_q <= 1'b0;
      oen_q <= 1'b1;
      regs_q <= '0;
    end else begin
      ist_q <= ist_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ix_q <= ix_d;
      rw_q <= rw_d;
      oen_q <= oen_d;
      regs_q <= regs_d;
    end
  end
  assign sda_drv = 1'b0;
  assign sda_oe_n = oen_q;

  // Register snapshot to the system domain by toggle handshake; the
  // snapshot stays still until the toggle comes back.
  flc_cfg_t snap_q, snap_d;
  logic req_q, req_d;
  always_comb begin
    snap_d = snap_q;
    req_d = req_q;
    if (req_q == ack_q[1] && regs_q != snap_q) begin
      snap_d = regs_q;
      req_d = !req_q;
    end
  end
  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      snap_q <= '0;
      req_q <= 1'b0;
    end else begin
      snap_q <= snap_d;
      req_q <= req_d;
    end
  end

  // ---- System domain ----
  flc_sense_t sn_m_q, sn_q;
  logic [1:0] ssh_q;
  logic [1:0] req_s_q;
  flc_cfg_t cfg_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sn_m_q <= '0;
      sn_q <= '0;
      ssh_q <= 2'h0;
      req_s_q <= 2'h0;
      ack_tg_q <= 1'b0;
      cfg_q <= '0;
    end else begin
      sn_m_q <= sense;
      sn_q <= sn_m_q;
      ssh_q <= {ssh_q[0], shutdown_n};
      req_s_q <= {req_s_q[0], req_q};
      ack_tg_q <= req_s_q[1];
      if (req_s_q[1] != ack_tg_q) cfg_q <= snap_q;
    end
  end
  assign sflg = {sn_q.above_ceil, sn_q.undervoltage_lockout_fault, sn_q.overtemp};

  // Flash duration in system clock cycles.
  function automatic logic [TMR_W-1:0] tmo_cyc(input logic [1:0] s);
    logic [TMR_W-1:0] c;
    c = TMR_W'(FLASH_CYC_0);
    unique case (s)
      2'h0: c = TMR_W'(FLASH_CYC_0);
      2'h1: c = TMR_W'(FLASH_CYC_1);
      2'h2: c = TMR_W'(FLASH_CYC_2);
      2'h3: c = TMR_W'(FLASH_CYC_3);
    endcase
    return c;
  endfunction : tmo_cyc

  // Flash output ceiling for a three-bit code.
  function automatic logic [MV_W-1:0] ceil_of(input logic [2:0] k);
    return MV_W'(CEIL_BASE_MV + CEIL_STEP_MV * k);
  endfunction : ceil_of

  // Requested gain clamped to what the voltage window permits.
  function automatic flc_gain_t pick(input logic [1:0] req,
      input logic lo, input logic hi);
    flc_gain_t g;
    g = G_2X;
    unique case (req)
      GAIN_AUTO: g = G_2X;
      GAIN_1X: g = G_1X;
      GAIN_15X: g = G_15X;
      GAIN_2X: g = G_2X;
    endcase
    if (lo) g = G_1X;
    else if (hi && g == G_1X) g = G_15X;
    else if (!hi && g == G_2X) g = G_15X;
    return g;
  endfunction : pick

  logic [1:0] mode;
  logic he;
  logic flash_m;
  logic torch_m;
  logic active;
  logic ffire;
  logic [2:0] en_sel;
  assign mode = cfg_q.mode[MODE_HI:MODE_LO];
  assign he = mode == MODE_TORCH &&
    cfg_q.mode[GAIN_HI:GAIN_LO] == GAIN_AUTO;
  assign flash_m = mode == MODE_FLASH;
  assign torch_m = mode == MODE_TORCH || mode == MODE_ATORCH;
  assign active = ssh_q[1] && mode != MODE_OFF;
  assign en_sel = flash_m ? cfg_q.flash[EN_HI:EN_LO]
    : cfg_q.torch[EN_HI:EN_LO];

  logic [TMR_W-1:0] tmr_q, tmr_d;
  logic exp_q, exp_d;
  flc_pst_t st_q, st_d;
  flc_pump_t pump_d;
  flc_drive_t drv_d;

  // Flash timer, pump sequencing and output selection. The timer is
  // re-armed only when the flash enables drop, flash mode is left or the
  // enable pin goes low.
  always_comb begin
    ffire = active && flash_m && en_sel != 3'h0 && !exp_q;
    tmr_d = ffire ? tmr_q + 1'b1 : '0;
    exp_d = exp_q;
    if (!(active && flash_m && en_sel != 3'h0)) exp_d = 1'b0;
    else if (ffire && tmr_q == tmo_cyc(cfg_q.mode[TMO_HI:TMO_LO])
        - 1'b1) exp_d = 1'b1;
    st_d = st_q;
    if (!active) begin
      st_d = PS_OFF;
    end else begin
      unique case (st_q)
        PS_OFF: st_d = PS_RUN;
        PS_RUN: if (sn_q.above_ceil) st_d = PS_WAIT;
        PS_WAIT: begin
          if (he) begin
            if (sn_q.headroom_low && !sn_q.above_ceil)
              st_d = PS_RUN;
          end else if (sn_q.below_rearm) begin
            st_d = PS_RUN;
          end
        end
      endcase
    end
    pump_d.on = active && st_d == PS_RUN && !sn_q.above_ceil;
    pump_d.gain = pick(cfg_q.mode[GAIN_HI:GAIN_LO],
      sn_q.below_in_1v, sn_q.above_in);
    pump_d.standby = active && en_sel == 3'h0 &&
      sn_q.above_ceil;
    pump_d.ceil_mv = flash_m ? ceil_of(cfg_q.ceil)
      : CEIL_TORCH_MV;
    pump_d.rearm_mv = pump_d.ceil_mv - HYST_MV;
    drv_d = '0;
    if (active && flash_m) begin
      drv_d.en = cfg_q.flash[EN_HI:EN_LO] & {3{!exp_d}};
      drv_d.flash_sel = 1'b1;
      drv_d.code = {1'b0, cfg_q.flash[FC_HI:FC_LO]};
    end else if (active && torch_m) begin
      drv_d.en = cfg_q.torch[EN_HI:EN_LO];
      drv_d.code = cfg_q.torch[TC_HI:TC_LO];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= '0;
      exp_q <= 1'b0;
      st_q <= PS_OFF;
      pump <= '0;
      drive <= '0;
    end else begin
      tmr_q <= tmr_d;
      exp_q <= exp_d;
      st_q <= st_d;
      pump <= pump_d;
      drive <= drv_d;
    end
  end

  // Checks on the pump controller and the register set.
  a_pump_off_above: assert property (@(posedge sys_clk)
    disable iff (!rst_n) sn_q.above_ceil |=> !pump.on)
    else $error("pump on above ceiling");
  a_unity_low: assert property (@(posedge sys_clk)
    disable iff (!rst_n) sn_q.below_in_1v |=> pump.gain == G_1X)
    else $error("gain not unity far below input");
  a_no_double_mid: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !sn_q.below_in_1v && !sn_q.above_in
    |=> pump.gain != G_2X)
    else $error("double gain just below input");
  a_no_unity_high: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !sn_q.below_in_1v && sn_q.above_in
    |=> pump.gain != G_1X)
    else $error("unity gain above input");
  a_torch_ceiling: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !flash_m |=> pump.ceil_mv == CEIL_TORCH_MV)
    else $error("torch ceiling wrong");
  a_flash_ceiling: assert property (@(posedge sys_clk)
    disable iff (!rst_n) flash_m
    |=> pump.ceil_mv == ceil_of($past(cfg_q.ceil)) &&
    pump.rearm_mv == pump.ceil_mv - HYST_MV)
    else $error("flash ceiling wrong");
  a_hyst_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_n) st_q == PS_WAIT && !he && !sn_q.below_rearm
    |=> !pump.on)
    else $error("pump restarted inside hysteresis");
  a_flash_expire: assert property (@(posedge sys_clk)
    disable iff (!rst_n) ffire &&
    tmr_q == tmo_cyc(cfg_q.mode[TMO_HI:TMO_LO]) - 1'b1
    |=> exp_q ##0 drive.en == 3'h0)
    else $error("flash not stopped at timeout");
  a_standby_dark: assert property (@(posedge sys_clk)
    disable iff (!rst_n) pump.standby |-> drive.en == 3'h0)
    else $error("standby with channel on");
  a_shutdown_off: assert property (@(posedge sys_clk)
    disable iff (!rst_n) !ssh_q[1] |=> !pump.on && drive == '0)
    else $error("output active while shut down");
  a_enable_clear: assert property (@(posedge link_clk)
    disable iff (!lrst_n) !lsh_q[1] |=> regs_q == '0)
    else $error("registers kept while shut down");
  a_retain_keep: assert property (@(posedge link_clk)
    disable iff (!lrst_n) lsh_q[1] && start &&
    regs_q.mode[RETAIN_BIT] |=> regs_q == $past(regs_q))
    else $error("retained registers changed at start");

  c_flash_timeout: cover property (@(posedge sys_clk)
    disable iff (!rst_n) $rose(exp_q));
  c_standby: cover property (@(posedge sys_clk)
    disable iff (!rst_n) $rose(pump.standby));
  c_pump_restart: cover property (@(posedge sys_clk)
    disable iff (!rst_n) st_q == PS_WAIT ##1 st_q == PS_RUN);
  c_read_byte: cover property (@(posedge link_clk)
    disable iff (!lrst_n) ist_q == I_RD ##1 ist_q == I_RACK);
endmodule : flc_top

// file: test/flc_host.sv
// Host controller model for the I2C target port: bit, byte and framing tasks.
// Assumes the bench resolves the pulled-up data wire and feeds it back.
`timescale 1ns/1ps
module flc_host (
  input wire logic clk, // Pacing clock for bit phases.
  input wire logic slow, // Adds a cycle to the low phase of every bit.
  input wire logic sda_w, // Resolved data wire level.
  output logic scl, // Clock line to the target.
  output logic sda_rel // High releases the data line.
);
  // Both lines idle released, as the pull-ups would leave them.
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end

  // Data changes only while the clock is low and is sampled late in the
  // high phase, so the target's synchroniser has long settled.
  task automatic bit_x(input logic b, output logic r);
    @(posedge clk) sda_rel <= b;
    if (slow) begin
      @(posedge clk);
    end
    @(posedge clk) scl <= 1'b1;
    @(posedge clk) r = sda_w;
    scl <= 1'b0;
  endtask : bit_x

  // Start also serves as a repeated start from a low clock.
  task automatic start_c();
    @(posedge clk) sda_rel <= 1'b1;
    @(posedge clk) scl <= 1'b1;
    @(posedge clk) sda_rel <= 1'b0;
    @(posedge clk) scl <= 1'b0;
  endtask : start_c

  // Stop: data rises while the clock is high.
  task automatic stop_c();
    @(posedge clk) sda_rel <= 1'b0;
    @(posedge clk) scl <= 1'b1;
    @(posedge clk) sda_rel <= 1'b1;
  endtask : stop_c

  // Byte out, most significant bit first, then the target's acknowledge.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wr_byte

  // Byte in; the last byte of a read is refused to end the transfer.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : flc_host

// file: test/tb_flc_top.sv
// Self-checking bench for the flash LED control block.
// Assumes the host model in flc_host and short flash timeout parameters.
`timescale 1ns/1ps
module tb_flc_top;
  import flc_pkg::*;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic nrst = 1'b0;
  logic shutdown_n = 1'b1;
  logic slow = 1'b0;
  logic scl;
  logic sda_rel;
  logic sda_o;
  logic sda_oe_n;
  logic sda_w;
  flc_sense_t sense = '0;
  flc_drive_t drive;
  flc_pump_t pump;
  int failures = 0;
  int samples_checked = 0;
  int run_len = 0;
  int last_len = 0;

  // Clocks: link edges fall every 6 ns, so they meet sys_clk's every 60 ns.
  always #20 sys_clk = ~sys_clk;
  always #3 link_clk = ~link_clk;

  // Pulled-up data wire: low when either party pulls it.
  assign sda_w = sda_rel & (sda_oe_n | sda_o);

  flc_top #(.FLASH_CYC_0(20), .FLASH_CYC_1(40), .FLASH_CYC_2(80),
    .FLASH_CYC_3(160)) flc_top_inst (.sys_clk(sys_clk), .nrst(nrst),
    .link_clk(link_clk), .shutdown_n(shutdown_n), .scl_pin(scl),
    .sda_pin(sda_w), .sda_drv(sda_o), .sda_oe_n(sda_oe_n), .sense(sense),
    .drive(drive), .pump(pump));

  flc_host flc_host_inst (.clk(sys_clk), .slow(slow), .sda_w(sda_w),
    .scl(scl), .sda_rel(sda_rel));

  // Length of the last stretch with channels enabled, for timeouts.
  always @(posedge sys_clk) begin
    if (drive.en !== 3'b000) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) last_len <= run_len;
      run_len <= 0;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // Write n bytes taken from the top of d; a foreign address is refused.
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input int n);
    logic k;
    flc_host_inst.start_c();
    flc_host_inst.wr_byte({a, 1'b0}, k);
    chk(k, a == I2C_ADDR);
    if (k) begin
      for (int i = 0; i < n; i++) begin
        flc_host_inst.wr_byte(d[31-8*i -: 8], k);
        chk(k, 1'b1);
      end
    end
    flc_host_inst.stop_c();
    repeat (8) @(posedge sys_clk);
  endtask : wr

  // Read status, flash and torch bytes and compare them in order.
  task automatic rd(input logic [23:0] e);
    logic k;
    logic [7:0] b;
    flc_host_inst.start_c();
    flc_host_inst.wr_byte({I2C_ADDR, 1'b1}, k);
    chk(k, 1'b1);
    for (int i = 0; i < 3; i++) begin
      flc_host_inst.rd_byte(i == 2, b);
      chk(b, e[23-8*i -: 8]);
    end
    flc_host_inst.stop_c();
  endtask : rd

  // Sense levels change, then the synchronised answer is given time.
  task automatic sn(input logic [6:0] v);
    @(posedge sys_clk) sense <= v;
    repeat (5) @(posedge sys_clk);
  endtask : sn

  // Expected gain: request clamped to what the voltage window allows.
  function automatic logic [1:0] exp_gain(input int g, input int c);
    int lvl;
    int lo;
    int hi;
    lvl = (g == 0) ? 2 : g - 1;
    lo = (c == 2) ? 1 : 0;
    hi = (c == 0) ? 0 : (c == 1) ? 1 : 2;
    return 2'(lvl < lo ? lo : (lvl > hi ? hi : lvl));
  endfunction : exp_gain

  // Watchdog sized well beyond the expected run of some 2,800 cycles.
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk(drive, 8'h00);
    chk({pump.on, pump.standby, pump.gain}, 4'h1);
    rd(24'h00_0000);
    wr(I2C_ADDR, 32'hE3AC_7EA0, 4);
    chk(drive, 8'hb3);
    chk(pump.ceil_mv, 13'h14b4);
    chk(pump.rearm_mv, 13'h1482);
    sn(7'h02);
    rd(24'hA8_AC7E);
    sn(7'h41);
    rd(24'hB4_AC7E);
    chk(pump.on, 1'b0);
    wr(I2C_ADDR, 32'hA000_0000, 1);
    sn(7'h00);
    chk(drive, 8'h6f);
    chk(pump.ceil_mv, 13'h1194);
    rd(24'hA0_AC7E);
    wr(7'h29, 32'h0000_0000, 3);
    rd(24'hA0_AC7E);
    sn(7'h40);
    chk(pump.on, 1'b0);
    sn(7'h00);
    chk(pump.on, 1'b0);
    sn(7'h20);
    chk(pump.on, 1'b1);
    for (int g = 0; g < 4; g++) begin
      wr(I2C_ADDR, {8'hA0 | 8'(g << 3), 24'h00_0000}, 1);
      for (int c = 0; c < 3; c++) begin
        sn(c == 0 ? 7'h10 : (c == 1 ? 7'h00 : 7'h08));
        chk(pump.gain, exp_gain(g, c));
      end
    end
    wr(I2C_ADDR, 32'h6000_0000, 1);
    sn(7'h40);
    sn(7'h04);
    chk(pump.on, 1'b1);
    wr(I2C_ADDR, 32'hA0AC_1E00, 3);
    sn(7'h40);
    chk(pump.standby, 1'b1);
    chk(drive.en, 3'b000);
    sn(7'h00);
    chk(pump.standby, 1'b0);
    // Leaving flash mode re-arms the timer before each duration code.
    for (int t = 0; t < 4; t++) begin
      wr(I2C_ADDR, 32'hA000_0000, 1);
      slow <= (t == 3);
      wr(I2C_ADDR, {8'hE0 | 8'(t), 24'h00_0000}, 1);
      repeat ((20 << t) + 20) @(posedge sys_clk);
      chk(last_len >= (20 << t) - 1 && last_len <= (20 << t) + 2,
        1'b1);
    end
    slow <= 1'b0;
    shutdown_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk(drive, 8'h00);
    chk({pump.on, pump.standby, pump.gain}, 4'h1);
    shutdown_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rd(24'h00_0000);
    wr(I2C_ADDR, 32'h80AC_7E00, 3);
    chk(drive, 8'h6f);
    rd(24'h00_0000);
    repeat (8) @(posedge sys_clk);
    chk(drive, 8'h00);
    close_out();
  end
endmodule : tb_flc_top
